// File: include/bdsr_consts.svh
// Timing, layout and reset constants for the digit scan block
`ifndef BDSR_CONSTS_SVH
`define BDSR_CONSTS_SVH

// System clock rate in Hz (8 ns period)
`define BDSR_CLK_HZ 125000000
// Nominal full scan rate of all four digit slots, in Hz
`define BDSR_SCAN_HZ 640
// Nominal full scan period, in ns
`define BDSR_SCAN_PERIOD_NS 1562500
// Digit slots in one scan
`define BDSR_SLOTS 4
// Cycles per digit slot, derived from the scan period
`define BDSR_SLOT_CYCLES (`BDSR_SCAN_PERIOD_NS / (`BDSR_SLOTS * 8))
// Nominal result rate, in results per second
`define BDSR_RESULT_HZ 3
// Speed-up factor of the fast conversion variant
`define BDSR_FAST_FACTOR 4
// Cycles between results at the nominal rate
`define BDSR_RESULT_CYCLES (`BDSR_CLK_HZ / `BDSR_RESULT_HZ)
// Result buffer depth, in words
`define BDSR_FIFO_DEPTH 16
// Code bit positions in the top digit slot
`define BDSR_TOP_LEAD_BIT 0
`define BDSR_TOP_UNDER_BIT 2
`define BDSR_TOP_OVER_BIT 3
// Reset values of the outputs
`define BDSR_CODE_RST 4'h0
`define BDSR_SEL_RST 4'h0

`endif

// File: include/bdsr_pkg.sv
// Types shared by the digit scan block
package bdsr_pkg;

    // One measurement result as it enters the scanner
    typedef struct packed {
        logic sign_neg;
        logic over;
        logic under;
        logic lead_one;
        logic [3:0] d3;
        logic [3:0] d2;
        logic [3:0] d1;
    } bdsr_result_type;

    // Digit slots in scan order
    typedef enum logic [1:0] {
        SLOT_D1,
        SLOT_D3,
        SLOT_D2,
        SLOT_D4
    } bdsr_slot_type;

    // What the scanner puts on its pins
    typedef struct packed {
        logic [3:0] code;
        logic [3:0] sel;
        logic sign_neg;
    } bdsr_pins_type;

endpackage

// File: tb/bdsr_reorder.sv
// Far-side reorder logic: two scans give one 1-2-3-4 readout
`timescale 1ns/1ps
module bdsr_reorder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Meter pins
    input wire logic [3:0] bcd_q,
    input wire logic [3:0] digit_sel_q,
    // Reordered readout
    output logic [3:0] out_code,
    output logic [3:0] out_sel
);
    logic pair_q, pair_d, top_q, top_d;
    // Toggle seen combinationally so digit one is not lost in its first cycle
    always_comb begin
        top_d = digit_sel_q[3];
        pair_d = pair_q ^ (top_q & !digit_sel_q[3]);
    end
    always_ff @(posedge clk_sys) begin
        pair_q <= reset_n ? pair_d : 1'b0;
        top_q <= reset_n ? top_d : 1'b0;
    end
    assign out_code = digit_sel_q[3] ? {3'h0, bcd_q[0]} : bcd_q;
    assign out_sel = digit_sel_q & (pair_d ? 4'hC : 4'h3);
endmodule

// File: tb/bdsr_scan_assertions.sv
// Checker of the digit scan pins
`timescale 1ns/1ps
`include "bdsr_consts.svh"
module bdsr_scan_chk #(
    parameter int unsigned SLOT_CYCLES = `BDSR_SLOT_CYCLES
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Readout pins and status
    input wire logic [3:0] bcd_q,
    input wire logic [3:0] digit_sel_q,
    input wire logic sign_neg_q,
    input wire logic scan_end,
    input wire logic result_load
);
    // Sized to hold a full scan at any slot length; top bit marks no scan end since reset
    localparam int GW = $clog2(4 * SLOT_CYCLES) + 2;
    logic [GW-1:0] gap_q, gap_d;
    function automatic logic [3:0] nxt(input logic [3:0] s);
        return (s == 4'h1) ? 4'h4 : (s == 4'h4) ? 4'h2 : (s == 4'h2) ? 4'h8 : 4'h1;
    endfunction
    always_comb begin
        gap_d = gap_q;
        if (clk_en) begin
            gap_d = scan_end ? '0 : gap_q + GW'(1);
        end
    end
    always_ff @(posedge clk_sys) begin
        gap_q <= reset_n ? gap_d : {1'b1, (GW-1)'(0)};
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sel_onehot_a: assert property ($onehot0(digit_sel_q))
        else $error("selects not one-hot");
    scan_order_a: assert property ((digit_sel_q != 4'h0 && $past(digit_sel_q) != 4'h0
        && digit_sel_q != $past(digit_sel_q)) |-> digit_sel_q == nxt($past(digit_sel_q)))
        else $error("slot order broken");
    scan_period_a: assert property (scan_end && clk_en && !gap_q[GW-1] |-> gap_q == GW'(4 * SLOT_CYCLES - 1))
        else $error("scan period wrong");
    scan_start_a: assert property (scan_end |=> digit_sel_q == 4'h1 || digit_sel_q == 4'h0)
        else $error("scan does not restart at digit one");
    top_bits_a: assert property (digit_sel_q[3] |-> !bcd_q[1])
        else $error("top slot weight 2 set");
    low_bcd_a: assert property (digit_sel_q[2:0] != 3'h0 |-> bcd_q <= 4'h9)
        else $error("digit code not decimal");
    sign_slot_a: assert property (digit_sel_q[2:0] != 3'h0 |-> !sign_neg_q)
        else $error("sign outside top slot");
    load_end_a: assert property (result_load |-> scan_end)
        else $error("load away from scan end");
    freeze_pins_a: assert property (!clk_en |=> $stable(digit_sel_q) && $stable(bcd_q))
        else $error("pins moved while frozen");
endmodule
bind bdsr_scan bdsr_scan_chk #(.SLOT_CYCLES(SLOT_CYCLES)) i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .bcd_q(bcd_q), .digit_sel_q(digit_sel_q), .sign_neg_q(sign_neg_q),
    .scan_end(scan_end), .result_load(result_load));

// File: tb/testbench.sv
// Self-checking bench of the digit scan block
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic result_valid = 1'b0;
    logic fast_rate = 1'b0;
    logic full_seen = 1'b0;
    logic result_ready, scan_end, result_load, sign_neg_q;
    logic [3:0] bcd_q, digit_sel_q, out_code, out_sel, last_sel;
    logic [15:0] rnd = 16'h0023;
    bdsr_pkg::bdsr_result_type result_in = '0;
    bdsr_pkg::bdsr_result_type shown, q[$];
    int err_total = 0;
    int num_checks = 0;
    int g;
    always #4 clk_sys = ~clk_sys;
    bdsr_scan #(.SLOT_CYCLES(4), .RESULT_CYCLES(40)) i_bdsr_scan (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .result_in(result_in), .result_valid(result_valid), .result_ready(result_ready),
        .fast_rate(fast_rate), .bcd_q(bcd_q), .digit_sel_q(digit_sel_q), .sign_neg_q(sign_neg_q),
        .scan_end(scan_end), .result_load(result_load));
    bdsr_reorder i_bdsr_reorder (.clk_sys(clk_sys), .reset_n(reset_n), .bcd_q(bcd_q),
        .digit_sel_q(digit_sel_q), .out_code(out_code), .out_sel(out_sel));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [3:0] exp_code(input bdsr_pkg::bdsr_result_type r, input logic [3:0] s);
        case (s)
            4'h1: return r.d1;
            4'h2: return r.d2;
            4'h4: return r.d3;
            default: return {r.over, r.under, 1'b0, r.lead_one};
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rst();
        @(posedge clk_sys) reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) check("reset pins", {digit_sel_q, bcd_q}, 16'h0000);
        @(posedge clk_sys) reset_n <= 1'b1;
    endtask
    // Data is held while refused; BCD digits stay within 0 to 9
    task automatic feed(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            rnd = lfsr(rnd);
            clk_en <= rnd[0] | rnd[1];
            if (!result_valid || (result_ready && clk_en))
                result_in <= {rnd[15:12], 4'(rnd[11:8] % 4'hA), 4'(rnd[7:4] % 4'hA), 4'(rnd[3:0] % 4'hA)};
            result_valid <= 1'b1;
        end
        @(posedge clk_sys);
        result_valid <= 1'b0;
        clk_en <= 1'b1;
    endtask
    task automatic gap();
        @(posedge clk_sys iff result_load);
        g = 0;
        do begin
            @(posedge clk_sys);
            g++;
        end while (!result_load && g < 200);
    endtask
    always @(posedge clk_sys) begin
        if (reset_n && result_valid && !result_ready) full_seen <= 1'b1;
        if (reset_n && clk_en && result_valid && result_ready) q.push_back(result_in);
    end
    always @(negedge clk_sys) begin
        if (!reset_n) begin
            shown = '0;
            q.delete();
            last_sel = 4'h8;
        end else begin
            if (shown.over) check("blank sel", digit_sel_q, 4'h0);
            else if (digit_sel_q != 4'h0) check("code", bcd_q, exp_code(shown, digit_sel_q));
            if (digit_sel_q[3]) check("sign", sign_neg_q, shown.sign_neg);
            if (out_sel != 4'h0 && out_sel != last_sel) begin
                check("reorder sel", out_sel, {last_sel[2:0], last_sel[3]});
                last_sel = out_sel;
            end
            if (out_sel[3]) check("top out", out_code[3:1], 3'h0);
            if (result_load && clk_en && q.size() > 0) shown = q.pop_front();
        end
    end
    initial begin
        #(8 * 40000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        rst();
        feed(300);
        check("fifo refused", full_seen, 1'b1);
        $display("end random fill");
        fast_rate <= 1'b1;
        gap();
        check("fast gap", g, 16'd16);
        repeat (3000) if (q.size() != 0) @(posedge clk_sys);
        @(negedge clk_sys) check("drained ready", {q.size() == 0, result_ready}, 16'h0003);
        $display("end drain");
        fast_rate <= 1'b0;
        feed(40);
        gap();
        check("slow gap", g == 32 || g == 48, 1'b1);
        $display("end slow rate");
        rst();
        feed(60);
        repeat (3000) if (q.size() != 0) @(posedge clk_sys);
        check("after reset", q.size() == 0, 1'b1);
        $display("end mid reset");
        tally_and_finish();
    end
endmodule

// File: verilog/bdsr_fifo.sv
// Result buffer with valid/ready on both sides
`timescale 1ns/1ps
module bdsr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop, full, empty;

    // Depth must be a power of two for the wrap bit to work
    assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && !full && clk_en;
    assign pop = out_ready && !empty && clk_en;

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            wr_d = wr_q + (AW+1)'(1);
        end
        if (pop) begin
            rd_d = rd_q + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// File: verilog/bdsr_pace.sv
// Result pacing timer, nominal or quadrupled rate
`timescale 1ns/1ps
`include "bdsr_consts.svh"
module bdsr_pace #(
    parameter int unsigned NORM_CYCLES = `BDSR_RESULT_CYCLES,
    parameter int unsigned FAST_FACTOR = `BDSR_FAST_FACTOR
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Rate select
    input wire logic fast_rate,
    // One-cycle tick per result period
    output logic tick
);
    localparam int CW = $clog2(NORM_CYCLES + 1);
    localparam int unsigned FAST_CYCLES = (NORM_CYCLES / FAST_FACTOR) > 0 ? NORM_CYCLES / FAST_FACTOR : 1;

    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] last;

    // A rate change takes effect at once; a count already past the new end ticks and wraps on the next enabled cycle
    assign last = fast_rate ? CW'(FAST_CYCLES - 1) : CW'(NORM_CYCLES - 1);
    assign tick = clk_en && (cnt_q >= last);

    always_comb begin
        cnt_d = cnt_q;
        if (clk_en) begin
            cnt_d = (cnt_q >= last) ? '0 : cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// File: verilog/bdsr_scan.sv
// Multiplexed BCD digit scanner of a 3 1/2 digit readout
// How it works
// - Digit codes on four high-true BCD lines
// - One high-true select per addressed digit
// - All digits share one time-multiplexed code bus
// - Top slot carries under/over on bits 4,8
// - Scan order digit 1, 3, 2, 4, repeat
// - Over range blanks all selects while present
// - Full four-slot scan at nominal 640 Hz
// - About three results/second, fast variant twelve
// - Top digit shows one or nothing only
// - Top slot also carries the reading sign
`timescale 1ns/1ps
`include "bdsr_consts.svh"
module bdsr_scan #(
    parameter int unsigned SLOT_CYCLES = `BDSR_SLOT_CYCLES,
    parameter int unsigned RESULT_CYCLES = `BDSR_RESULT_CYCLES,
    parameter int unsigned FAST_FACTOR = `BDSR_FAST_FACTOR,
    parameter int FIFO_DEPTH = `BDSR_FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Measurement results from the converter
    input wire bdsr_pkg::bdsr_result_type result_in,
    input wire logic result_valid,
    output logic result_ready,
    // Conversion rate select
    input wire logic fast_rate,
    // Readout pins
    output logic [3:0] bcd_q,
    output logic [3:0] digit_sel_q,
    output logic sign_neg_q,
    // Status
    output logic scan_end,
    output logic result_load
);
    localparam int RW = $bits(bdsr_pkg::bdsr_result_type);
    localparam int CW = $clog2(SLOT_CYCLES + 1);

    bdsr_pkg::bdsr_result_type fifo_data, shown_q, shown_d, pend_q, pend_d;
    logic fifo_valid, fifo_pop, pace_tick;
    logic pend_full_q, pend_full_d;
    bdsr_pkg::bdsr_slot_type slot_q, slot_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic slot_wrap, scan_wrap;
    bdsr_pkg::bdsr_pins_type pins_q, pins_d;

    // Select line for a slot, decoded for the pin drive only
    function automatic logic [3:0] slot_select(input bdsr_pkg::bdsr_slot_type s);
        logic [3:0] r;
        r = 4'h0;
        unique case (s)
            bdsr_pkg::SLOT_D1: r = 4'h1;
            bdsr_pkg::SLOT_D2: r = 4'h2;
            bdsr_pkg::SLOT_D3: r = 4'h4;
            bdsr_pkg::SLOT_D4: r = 4'h8;
        endcase
        return r;
    endfunction

    // Code placed on the shared BCD lines for a slot
    function automatic logic [3:0] slot_code(input bdsr_pkg::bdsr_slot_type s,
                                             input bdsr_pkg::bdsr_result_type v);
        logic [3:0] r;
        r = 4'h0;
        unique case (s)
            bdsr_pkg::SLOT_D1: r = v.d1;
            bdsr_pkg::SLOT_D2: r = v.d2;
            bdsr_pkg::SLOT_D3: r = v.d3;
            bdsr_pkg::SLOT_D4: begin
                r[`BDSR_TOP_LEAD_BIT] = v.lead_one;
                r[`BDSR_TOP_UNDER_BIT] = v.under;
                r[`BDSR_TOP_OVER_BIT] = v.over;
            end
        endcase
        return r;
    endfunction

    bdsr_fifo #(
        .WIDTH(RW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_data(result_in),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    bdsr_pace #(
        .NORM_CYCLES(RESULT_CYCLES),
        .FAST_FACTOR(FAST_FACTOR)
    ) u_pace (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .fast_rate(fast_rate),
        .tick(pace_tick)
    );

    // One result leaves the buffer per pacing tick while the holding word is empty; the buffer fills while the display lags
    assign fifo_pop = pace_tick && fifo_valid && !pend_full_q;

    // Slot timing
    assign slot_wrap = clk_en && (cnt_q == CW'(SLOT_CYCLES - 1));
    assign scan_wrap = slot_wrap && (slot_q == bdsr_pkg::SLOT_D4);
    assign scan_end = scan_wrap;
    assign result_load = scan_wrap && pend_full_q;

    always_comb begin
        cnt_d = cnt_q;
        slot_d = slot_q;
        if (clk_en) begin
            cnt_d = slot_wrap ? '0 : cnt_q + CW'(1);
        end
        if (slot_wrap) begin
            unique case (slot_q)
                bdsr_pkg::SLOT_D1: slot_d = bdsr_pkg::SLOT_D3;
                bdsr_pkg::SLOT_D3: slot_d = bdsr_pkg::SLOT_D2;
                bdsr_pkg::SLOT_D2: slot_d = bdsr_pkg::SLOT_D4;
                bdsr_pkg::SLOT_D4: slot_d = bdsr_pkg::SLOT_D1;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= '0;
            slot_q <= bdsr_pkg::SLOT_D1;
        end else begin
            cnt_q <= cnt_d;
            slot_q <= slot_d;
        end
    end

    // A new result waits in a holding word and is shown only from a scan boundary,
    // so no scan ever mixes digits of two readings
    always_comb begin
        pend_d = pend_q;
        pend_full_d = pend_full_q;
        shown_d = shown_q;
        if (result_load) begin
            shown_d = pend_q;
            pend_full_d = 1'b0;
        end
        if (fifo_pop) begin
            pend_d = fifo_data;
            pend_full_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pend_q <= '0;
            pend_full_q <= 1'b0;
            shown_q <= '0;
        end else begin
            pend_q <= pend_d;
            pend_full_q <= pend_full_d;
            shown_q <= shown_d;
        end
    end

    // Pin drive; the code bus keeps running while blanked so timing stays intact
    always_comb begin
        pins_d = pins_q;
        if (clk_en) begin
            pins_d.code = slot_code(slot_d, shown_d);
            pins_d.sel = shown_d.over ? 4'h0 : slot_select(slot_d);
            pins_d.sign_neg = (slot_d == bdsr_pkg::SLOT_D4) && shown_d.sign_neg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pins_q <= '{code: `BDSR_CODE_RST, sel: `BDSR_SEL_RST, sign_neg: 1'b0};
        end else begin
            pins_q <= pins_d;
        end
    end

    assign bcd_q = pins_q.code;
    assign digit_sel_q = pins_q.sel;
    assign sign_neg_q = pins_q.sign_neg;
endmodule
